// ### design/aclh_defines.vh
// Constants for the AC-link host controller: map, fields, frame layout
`ifndef ACLH_DEFINES_VH
`define ACLH_DEFINES_VH

// Frame layout on the link
`define ACLH_FRAME_BITS 256
`define ACLH_CNT_W 8
`define ACLH_TAG_BITS 16
`define ACLH_SLOT_W 20
`define ACLH_NUM_SLOTS 12
`define ACLH_SYNC_BITS 8'd16
`define ACLH_LAST_POS 8'hff
`define ACLH_ARM_CNT 8'd1
`define ACLH_UNUSED_W 140
`define ACLH_TAG_PAD 3

// Command and status slot fields
`define ACLH_S1_PAD 12
`define ACLH_S2_PAD 4
`define ACLH_SIDX_HI 18
`define ACLH_SIDX_LO 12
`define ACLH_SDAT_HI 19
`define ACLH_SDAT_LO 4
`define ACLH_IDX_W 7
`define ACLH_DAT_W 16

// Register byte offsets on the APB side
`define ACLH_A_CTRL 8'h00
`define ACLH_A_STAT 8'h04
`define ACLH_A_CMD 8'h08
`define ACLH_A_RESP 8'h0c
`define ACLH_A_PCM_L 8'h10
`define ACLH_A_PCM_R 8'h14
`define ACLH_A_MDM_TX 8'h18
`define ACLH_A_REC_L 8'h1c
`define ACLH_A_REC_R 8'h20
`define ACLH_A_MDM_RX 8'h24
`define ACLH_A_MIC 8'h28

// Register field positions
`define ACLH_CTRL_EN 0
`define ACLH_CTRL_MONO 1
`define ACLH_ST_READY 0
`define ACLH_ST_CMD 1
`define ACLH_ST_RESP 2
`define ACLH_ST_FULL_LO 3
`define ACLH_ST_ODD 6
`define ACLH_ST_TAG_LO 16
`define ACLH_CMD_DAT_LO 0
`define ACLH_CMD_IDX_LO 16
`define ACLH_CMD_RD 23
`define ACLH_NEW_BIT 31

`endif

// ### design/aclh_sync.v
// Two-flop synchroniser for link pins entering the system clock domain
`timescale 1ns/1ps
`default_nettype none
module aclh_sync #(
  parameter WIDTH = 2
) (
  // Clock and reset
  input wire CLK_IN,
  input wire RST_B_IN,
  // Asynchronous levels in, synchronised levels out
  input wire [WIDTH-1:0] D_IN,
  output reg [WIDTH-1:0] Q_OUT
);
  reg [WIDTH-1:0] meta;

  // First stage feeds only the second stage
  always @(posedge CLK_IN) begin
    if (!RST_B_IN) begin
      meta <= {WIDTH{1'b0}};
      Q_OUT <= {WIDTH{1'b0}};
    end else begin
      meta <= D_IN;
      Q_OUT <= meta;
    end
  end
endmodule
`default_nettype wire

// ### design/aclh_ctrl.v
// AC-link host controller: frame generator, slot packer and APB registers
//
// The placing of the registers and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "aclh_defines.vh"
module aclh_ctrl #(
  parameter NUM_TX = 3,
  parameter NUM_RX = 4
) (
  // Clock and reset
  input wire CLK_IN,
  input wire RST_B_IN,
  // APB slave
  input wire PSEL_IN,
  input wire PENABLE_IN,
  input wire PWRITE_IN,
  input wire [7:0] PADDR_IN,
  input wire [31:0] PWDATA_IN,
  output reg [31:0] PRDATA_OUT,
  output reg PREADY_OUT,
  output reg PSLVERR_OUT,
  // AC-link pins
  input wire BIT_CLK_IN,
  input wire SDATA_IN_IN,
  output reg SYNC_OUT,
  output reg SDATA_OUT_OUT
);
  // Pick one 20-bit slot word out of a whole frame
  function [`ACLH_SLOT_W-1:0] slot_word;
    input [`ACLH_FRAME_BITS-1:0] f;
    input integer k;
    reg [`ACLH_FRAME_BITS-1:0] t;
    begin
      t = f >> (`ACLH_FRAME_BITS - `ACLH_TAG_BITS - `ACLH_SLOT_W * k);
      slot_word = t[`ACLH_SLOT_W-1:0];
    end
  endfunction

  wire [1:0] pins_sync;
  wire bclk;
  wire sdin;
  reg bclk_d;
  reg [`ACLH_CNT_W-1:0] cnt;
  reg [`ACLH_CNT_W-1:0] rx_pos;
  reg rx_arm;
  reg rx_done;
  reg [`ACLH_FRAME_BITS-1:0] tx_sr;
  reg [`ACLH_FRAME_BITS-1:0] rx_sr;
  reg link_en;
  reg mono;
  reg codec_ready;
  reg [`ACLH_NUM_SLOTS-1:0] rx_tags;
  reg cmd_pend;
  reg cmd_rd;
  reg [`ACLH_IDX_W-1:0] cmd_idx;
  reg [`ACLH_DAT_W-1:0] cmd_dat;
  reg odd_err;
  reg resp_valid;
  reg [`ACLH_IDX_W-1:0] resp_idx;
  reg [`ACLH_DAT_W-1:0] resp_dat;
  reg [`ACLH_SLOT_W-1:0] pb_val [0:NUM_TX-1];
  reg [NUM_TX-1:0] pb_full;
  reg [`ACLH_SLOT_W-1:0] rec_val [0:NUM_RX-1];
  reg [NUM_RX-1:0] rec_new;
  reg [31:0] next_prdata;
  reg next_err;
  integer i;

  // Bit clock and input data cross into the system clock here
  aclh_sync #(
    .WIDTH(2)
  ) u_sync (
    .CLK_IN(CLK_IN),
    .RST_B_IN(RST_B_IN),
    .D_IN({BIT_CLK_IN, SDATA_IN_IN}),
    .Q_OUT(pins_sync)
  );
  assign bclk = pins_sync[1];
  assign sdin = pins_sync[0];

  // Edges of the device-made bit clock
  wire bclk_rise = bclk & ~bclk_d;
  wire bclk_fall = ~bclk & bclk_d;
  wire frame_load = bclk_rise & link_en & (cnt == {`ACLH_CNT_W{1'b0}});

  wire cmd_go = cmd_pend & codec_ready;

  // per-slot tags, slot 1 in the top bit
  wire [`ACLH_NUM_SLOTS-1:0] tx_tags;
  // mono mode tags right slot with left data
  assign tx_tags = {cmd_go, cmd_go & ~cmd_rd, pb_full[0],
    mono ? pb_full[0] : pb_full[1], pb_full[2], {(`ACLH_NUM_SLOTS-5){1'b0}}};

  wire [`ACLH_SLOT_W-1:0] s1 = cmd_go ? {cmd_rd, cmd_idx, {`ACLH_S1_PAD{1'b0}}} :
    {`ACLH_SLOT_W{1'b0}};
  // write data only, zero slot on reads
  wire [`ACLH_SLOT_W-1:0] s2 = (cmd_go & ~cmd_rd) ? {cmd_dat, {`ACLH_S2_PAD{1'b0}}} :
    {`ACLH_SLOT_W{1'b0}};
  // samples are left-aligned, trailing bits already zero
  wire [`ACLH_SLOT_W-1:0] s3 = pb_full[0] ? pb_val[0] : {`ACLH_SLOT_W{1'b0}};
  // right slot repeats left sample in mono mode
  wire [`ACLH_SLOT_W-1:0] s4 = mono ? s3 :
    (pb_full[1] ? pb_val[1] : {`ACLH_SLOT_W{1'b0}});
  // modem DAC stream in slot 5
  wire [`ACLH_SLOT_W-1:0] s5 = pb_full[2] ? pb_val[2] : {`ACLH_SLOT_W{1'b0}};

  // tag slot then twelve data slots
  // frame valid when any slot tag is set
  // slots 6 to 12 are sent as zero, untagged
  wire [`ACLH_FRAME_BITS-1:0] next_frame = {|tx_tags, tx_tags, {`ACLH_TAG_PAD{1'b0}},
    s1, s2, s3, s4, s5, {`ACLH_UNUSED_W{1'b0}}};

  // Frame sequencing on bit clock edges
  always @(posedge CLK_IN) begin
    if (!RST_B_IN) begin
      bclk_d <= 1'b0;
      cnt <= {`ACLH_CNT_W{1'b0}};
      rx_pos <= {`ACLH_CNT_W{1'b0}};
      rx_arm <= 1'b0;
      rx_done <= 1'b0;
      tx_sr <= {`ACLH_FRAME_BITS{1'b0}};
      rx_sr <= {`ACLH_FRAME_BITS{1'b0}};
      SYNC_OUT <= 1'b0;
      SDATA_OUT_OUT <= 1'b0;
    end else begin
      bclk_d <= bclk;
      rx_done <= 1'b0;
      if (!link_en) begin
        cnt <= {`ACLH_CNT_W{1'b0}};
        rx_arm <= 1'b0;
        SYNC_OUT <= 1'b0;
        SDATA_OUT_OUT <= 1'b0;
        tx_sr <= {`ACLH_FRAME_BITS{1'b0}};
      end else if (bclk_rise) begin
        // SYNC high for the first 16 bit clocks
        SYNC_OUT <= (cnt < `ACLH_SYNC_BITS);
        cnt <= cnt + 1'b1;
        rx_pos <= cnt - 1'b1;
        // data trails SYNC by one bit clock
        SDATA_OUT_OUT <= tx_sr[`ACLH_FRAME_BITS-1];
        if (cnt == {`ACLH_CNT_W{1'b0}})
          tx_sr <= next_frame;
        else
          tx_sr <= {tx_sr[`ACLH_FRAME_BITS-2:0], 1'b0};
        if (cnt == `ACLH_ARM_CNT)
          rx_arm <= 1'b1;
      end else if (bclk_fall) begin
        // sample incoming bit on falling edge
        rx_sr <= {rx_sr[`ACLH_FRAME_BITS-2:0], sdin};
        if (rx_arm && rx_pos == `ACLH_LAST_POS)
          rx_done <= 1'b1;
      end
    end
  end

  // Incoming slot words of the frame just received
  wire [`ACLH_SLOT_W-1:0] r1 = slot_word(rx_sr, 1);
  wire [`ACLH_SLOT_W-1:0] r2 = slot_word(rx_sr, 2);
  wire [`ACLH_NUM_SLOTS-1:0] r_tags = rx_sr[`ACLH_FRAME_BITS-2 -: `ACLH_NUM_SLOTS];

  // APB access phases
  wire apb_setup = PSEL_IN & ~PENABLE_IN;
  wire apb_done = PSEL_IN & PENABLE_IN & PREADY_OUT;
  wire wr = apb_done & PWRITE_IN;
  wire rd = apb_done & ~PWRITE_IN;

  // Register state, link consumption and software access
  always @(posedge CLK_IN) begin
    if (!RST_B_IN) begin
      link_en <= 1'b0;
      mono <= 1'b0;
      codec_ready <= 1'b0;
      rx_tags <= {`ACLH_NUM_SLOTS{1'b0}};
      cmd_pend <= 1'b0;
      cmd_rd <= 1'b0;
      cmd_idx <= {`ACLH_IDX_W{1'b0}};
      cmd_dat <= {`ACLH_DAT_W{1'b0}};
      odd_err <= 1'b0;
      resp_valid <= 1'b0;
      resp_idx <= {`ACLH_IDX_W{1'b0}};
      resp_dat <= {`ACLH_DAT_W{1'b0}};
      pb_full <= {NUM_TX{1'b0}};
      rec_new <= {NUM_RX{1'b0}};
      for (i = 0; i < NUM_TX; i = i + 1)
        pb_val[i] <= {`ACLH_SLOT_W{1'b0}};
      for (i = 0; i < NUM_RX; i = i + 1)
        rec_val[i] <= {`ACLH_SLOT_W{1'b0}};
    end else begin
      // Clear-on-read first, so hardware sets below win
      if (rd && PADDR_IN == `ACLH_A_RESP)
        resp_valid <= 1'b0;
      for (i = 0; i < NUM_RX; i = i + 1)
        if (rd && PADDR_IN == `ACLH_A_REC_L + 8'h04 * i[7:0])
          rec_new[i] <= 1'b0;
      // Items packed into the frame now leave their holders
      if (frame_load) begin
        if (cmd_go)
          cmd_pend <= 1'b0;
        pb_full[0] <= 1'b0;
        if (!mono)
          pb_full[1] <= 1'b0;
        pb_full[2] <= 1'b0;
      end
      if (rx_done) begin
        // ready bit heads the incoming tag slot
        codec_ready <= rx_sr[`ACLH_FRAME_BITS-1];
        rx_tags <= rx_sr[`ACLH_FRAME_BITS-1] ? r_tags : {`ACLH_NUM_SLOTS{1'b0}};
        if (rx_sr[`ACLH_FRAME_BITS-1]) begin
          // read data taken when slots 1 and 2 tagged
          if (r_tags[`ACLH_NUM_SLOTS-1] && r_tags[`ACLH_NUM_SLOTS-2]) begin
            resp_valid <= 1'b1;
            resp_idx <= r1[`ACLH_SIDX_HI:`ACLH_SIDX_LO];
            resp_dat <= r2[`ACLH_SDAT_HI:`ACLH_SDAT_LO];
          end
          for (i = 0; i < NUM_RX; i = i + 1)
            if (r_tags[`ACLH_NUM_SLOTS-3-i]) begin
              rec_val[i] <= slot_word(rx_sr, 3 + i);
              rec_new[i] <= 1'b1;
            end
        end
      end
      if (wr) begin
        if (PADDR_IN == `ACLH_A_CTRL) begin
          link_en <= PWDATA_IN[`ACLH_CTRL_EN];
          mono <= PWDATA_IN[`ACLH_CTRL_MONO];
        end else if (PADDR_IN == `ACLH_A_CMD) begin
          if (PWDATA_IN[`ACLH_CMD_IDX_LO]) begin
            odd_err <= 1'b1;
          end else if (!cmd_pend) begin
            odd_err <= 1'b0;
            cmd_pend <= 1'b1;
            cmd_rd <= PWDATA_IN[`ACLH_CMD_RD];
            cmd_idx <= PWDATA_IN[`ACLH_CMD_IDX_LO +: `ACLH_IDX_W];
            cmd_dat <= PWDATA_IN[`ACLH_CMD_DAT_LO +: `ACLH_DAT_W];
          end
        end else if (PADDR_IN == `ACLH_A_PCM_L && !pb_full[0]) begin
          pb_val[0] <= PWDATA_IN[`ACLH_SLOT_W-1:0];
          pb_full[0] <= 1'b1;
        end else if (PADDR_IN == `ACLH_A_PCM_R && !pb_full[1]) begin
          pb_val[1] <= PWDATA_IN[`ACLH_SLOT_W-1:0];
          pb_full[1] <= 1'b1;
        end else if (PADDR_IN == `ACLH_A_MDM_TX && !pb_full[2]) begin
          pb_val[2] <= PWDATA_IN[`ACLH_SLOT_W-1:0];
          pb_full[2] <= 1'b1;
        end
      end
    end
  end

  // Read data and error decode for the current address
  always @* begin
    next_prdata = 32'h0000_0000;
    next_err = 1'b0;
    if (PADDR_IN == `ACLH_A_CTRL) begin
      next_prdata[`ACLH_CTRL_EN] = link_en;
      next_prdata[`ACLH_CTRL_MONO] = mono;
    end else if (PADDR_IN == `ACLH_A_STAT) begin
      next_prdata[`ACLH_ST_READY] = codec_ready;
      next_prdata[`ACLH_ST_CMD] = cmd_pend;
      next_prdata[`ACLH_ST_RESP] = resp_valid;
      next_prdata[`ACLH_ST_FULL_LO +: NUM_TX] = pb_full;
      next_prdata[`ACLH_ST_ODD] = odd_err;
      next_prdata[`ACLH_ST_TAG_LO +: `ACLH_NUM_SLOTS] = rx_tags;
    end else if (PADDR_IN == `ACLH_A_CMD) begin
      next_prdata[`ACLH_CMD_RD] = cmd_rd;
      next_prdata[`ACLH_CMD_IDX_LO +: `ACLH_IDX_W] = cmd_idx;
      next_prdata[`ACLH_CMD_DAT_LO +: `ACLH_DAT_W] = cmd_dat;
    end else if (PADDR_IN == `ACLH_A_RESP) begin
      next_prdata[`ACLH_NEW_BIT] = resp_valid;
      next_prdata[`ACLH_CMD_IDX_LO +: `ACLH_IDX_W] = resp_idx;
      next_prdata[`ACLH_CMD_DAT_LO +: `ACLH_DAT_W] = resp_dat;
    end else if (PADDR_IN == `ACLH_A_PCM_L) begin
      next_prdata[`ACLH_SLOT_W-1:0] = pb_val[0];
    end else if (PADDR_IN == `ACLH_A_PCM_R) begin
      next_prdata[`ACLH_SLOT_W-1:0] = pb_val[1];
    end else if (PADDR_IN == `ACLH_A_MDM_TX) begin
      next_prdata[`ACLH_SLOT_W-1:0] = pb_val[2];
    end else if (PADDR_IN == `ACLH_A_REC_L) begin
      next_prdata[`ACLH_NEW_BIT] = rec_new[0];
      next_prdata[`ACLH_SLOT_W-1:0] = rec_val[0];
    end else if (PADDR_IN == `ACLH_A_REC_R) begin
      next_prdata[`ACLH_NEW_BIT] = rec_new[1];
      next_prdata[`ACLH_SLOT_W-1:0] = rec_val[1];
    end else if (PADDR_IN == `ACLH_A_MDM_RX) begin
      next_prdata[`ACLH_NEW_BIT] = rec_new[2];
      next_prdata[`ACLH_SLOT_W-1:0] = rec_val[2];
    end else if (PADDR_IN == `ACLH_A_MIC) begin
      next_prdata[`ACLH_NEW_BIT] = rec_new[3];
      next_prdata[`ACLH_SLOT_W-1:0] = rec_val[3];
    end else begin
      next_err = 1'b1;
    end
  end

  // Zero-wait APB answer: ready in the first access cycle
  always @(posedge CLK_IN) begin
    if (!RST_B_IN) begin
      PREADY_OUT <= 1'b0;
      PSLVERR_OUT <= 1'b0;
      PRDATA_OUT <= 32'h0000_0000;
    end else begin
      PREADY_OUT <= apb_setup;
      PSLVERR_OUT <= apb_setup & next_err;
      if (apb_setup)
        PRDATA_OUT <= next_err ? 32'h0000_0000 : next_prdata;
    end
  end
endmodule
`default_nettype wire

// ### testbench/aclh_ctrl_sva.sv
// Port checker for the AC-link host controller
`timescale 1ns/1ps
`default_nettype none
module aclh_ctrl_sva #(
  parameter NUM_TX = 3,
  parameter NUM_RX = 4
) (
  // Clock and reset
  input wire logic CLK_IN,
  input wire logic RST_B_IN,
  // APB side
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [7:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  input wire logic [31:0] PRDATA_OUT,
  input wire logic PREADY_OUT,
  input wire logic PSLVERR_OUT,
  // Link side
  input wire logic BIT_CLK_IN,
  input wire logic SDATA_IN_IN,
  input wire logic SYNC_OUT,
  input wire logic SDATA_OUT_OUT
);
  logic bc_d, sy_f, sy_p, lo_ok, bad;
  logic [255:0] sh;
  logic [4:0] age;
  logic [8:0] hi_n, lo_n;
  wire rise = BIT_CLK_IN && !bc_d;
  wire fall = !BIT_CLK_IN && bc_d;
  wire [255:0] fr = {sh[254:0], SDATA_OUT_OUT};
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (!RST_B_IN);
  // Edge finder, frame capture and phase counters
  always_ff @(posedge CLK_IN) begin
    if (!RST_B_IN) begin
      {bc_d, sy_f, sy_p, lo_ok, sh, hi_n, lo_n} <= '0;
      age <= 5'h1f;
    end else begin
      bc_d <= BIT_CLK_IN;
      sy_p <= SYNC_OUT;
      lo_ok <= lo_ok || (sy_p && !SYNC_OUT);
      age <= rise ? 5'h00 : age + {4'h0, age != 5'h1f};
      if (fall) begin
        sh <= fr;
        sy_f <= SYNC_OUT;
      end
      if (SYNC_OUT && !sy_p) hi_n <= 9'h000;
      else if (SYNC_OUT && rise) hi_n <= hi_n + 9'h001;
      if (!SYNC_OUT && sy_p) lo_n <= 9'h000;
      else if (!SYNC_OUT && rise) lo_n <= lo_n + 9'h001;
    end
  end
  // Flags a slot carrying data without its tag
  always_comb begin
    bad = 1'b0;
    for (int i = 1; i <= 12; i++)
      if (!fr[255-i] && fr[259-20*i -: 20] != 20'h00000) bad = 1'b1;
  end
  sequence s_frame_end;
    fall && SYNC_OUT && !sy_f;
  endsequence
  a_sync_tag_len: assert property ($fell(SYNC_OUT) |-> hi_n == 9'd16)
    else $error("sync high phase length wrong");
  a_sync_data_len: assert property ($rose(SYNC_OUT) && lo_ok |-> lo_n == 9'd240)
    else $error("sync low phase length wrong");
  a_sync_on_rise: assert property ($rose(SYNC_OUT) |-> age <= 5'd5)
    else $error("sync not launched from a bit clock rise");
  a_data_on_rise: assert property ($changed(SDATA_OUT_OUT) |-> age <= 5'd5)
    else $error("serial data moved away from a rise");
  a_valid_flag: assert property (s_frame_end |-> fr[255] == (|fr[254:243]))
    else $error("frame valid flag disagrees with tags");
  a_untagged_zero: assert property (s_frame_end |-> !bad)
    else $error("untagged slot not zero");
  a_cmd_tail: assert property (s_frame_end ##0 fr[254] |-> fr[231:220] == 12'h000)
    else $error("command slot tail not zero");
  a_even_index: assert property (s_frame_end ##0 fr[254] |-> !fr[232])
    else $error("odd register index sent");
  a_read_slot2: assert property (s_frame_end ##0 (fr[254] && fr[239]) |-> !fr[253])
    else $error("read command tagged data slot");
  a_write_tail: assert property (s_frame_end ##0 fr[253] |-> fr[254] && !fr[239]
    && fr[203:200] == 4'h0)
    else $error("write data slot malformed");
  a_zero_wait: assert property (PSEL_IN && !PENABLE_IN |=> PREADY_OUT)
    else $error("ready missing in access cycle");
  a_err_ready: assert property (PSLVERR_OUT |-> PREADY_OUT)
    else $error("error without ready");
endmodule
bind aclh_ctrl aclh_ctrl_sva #(.NUM_TX(NUM_TX), .NUM_RX(NUM_RX)) u_sva (
  .CLK_IN(CLK_IN), .RST_B_IN(RST_B_IN), .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN),
  .PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN), .PWDATA_IN(PWDATA_IN),
  .PRDATA_OUT(PRDATA_OUT), .PREADY_OUT(PREADY_OUT), .PSLVERR_OUT(PSLVERR_OUT),
  .BIT_CLK_IN(BIT_CLK_IN), .SDATA_IN_IN(SDATA_IN_IN), .SYNC_OUT(SYNC_OUT),
  .SDATA_OUT_OUT(SDATA_OUT_OUT));
`default_nettype wire

// ### testbench/aclh_codec_model.sv
// Behavioural codec: bit clock, register file and record streams
`timescale 1ns/1ps
`default_nettype none
module aclh_codec_model (
  // Link pins
  output logic bit_clk_out,
  input wire logic sync_in,
  input wire logic sdata_out_in,
  output logic sdata_in_out
);
  logic [255:0] sh, got, tx;
  logic [15:0] regs [0:63];
  logic [6:0] ridx;
  logic sy_f, rdy, rsp;
  int nfr;
  // Idle state at start
  initial begin
    bit_clk_out = 1'b0;
    sdata_in_out = 1'b0;
    {sh, got, tx, ridx, sy_f, rdy, rsp} = '0;
    nfr = 0;
    foreach (regs[i]) regs[i] = 16'h0000;
  end
  always #40 bit_clk_out = ~bit_clk_out;
  always @(negedge bit_clk_out) begin
    sh = {sh[254:0], sdata_out_in};
    if (sync_in && !sy_f) begin
      got = sh;
      rdy = nfr > 0;
      if (sh[254] && sh[253] && !sh[239]) regs[sh[238:233]] = sh[219:204];
      rsp = rdy && sh[254] && sh[239];
      ridx = sh[238:232];
      tx = {rdy, rsp, rsp, {4{rdy}}, 9'h000,
        rsp ? {1'b0, ridx, 12'h000} : 20'h0, rsp ? {regs[ridx[6:1]], 4'h0} : 20'h0,
        rdy ? 80'hab5c0_6f3c4_9e1b0_35d28 : 80'h0, 120'h0};
      // Frame count moves last, so waiters see the register file updated
      nfr++;
    end
    sy_f = sync_in;
  end
  always @(posedge bit_clk_out) begin
    sdata_in_out <= tx[255];
    tx = {tx[254:0], 1'b0};
  end
endmodule
`default_nettype wire

// ### testbench/aclh_ctrl_tb.sv
// Self-checking bench for the AC-link host controller
`timescale 1ns/1ps
`default_nettype none
`include "aclh_defines.vh"
module aclh_ctrl_tb;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, bclk, sdi, sync, sdo, er;
  int num_errors = 0;
  int tests_run = 0;
  int cyc = 0;
  // 250 MHz system clock
  always #2 clk = ~clk;
  aclh_ctrl uut (
    .CLK_IN(clk), .RST_B_IN(rst_b), .PSEL_IN(psel), .PENABLE_IN(penable),
    .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
    .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .BIT_CLK_IN(bclk),
    .SDATA_IN_IN(sdi), .SYNC_OUT(sync), .SDATA_OUT_OUT(sdo));
  aclh_codec_model u_codec (.bit_clk_out(bclk), .sync_in(sync),
    .sdata_out_in(sdo), .sdata_in_out(sdi));
  task report_and_stop;
    if (num_errors == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  // One APB transfer, held until ready
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task wst(input int b, input logic v);
    do apb(1'b0, `ACLH_A_STAT, 32'h0);
    while (rd[b] !== v);
  endtask
  task t_regs;
    apb(1'b0, `ACLH_A_STAT, 32'h0);
    chk("stat", rd, 32'h0);
    apb(1'b0, 8'h3c, 32'h0);
    chk("err", {31'h0, er}, 32'h1);
    chk("errdata", rd, 32'h0);
    chk("sync", {31'h0, sync}, 32'h0);
  endtask
  task t_link;
    apb(1'b1, `ACLH_A_CMD, 32'h0002_1234);
    apb(1'b1, `ACLH_A_CTRL, 32'h1);
    wst(0, 1'b1);
    chk("early", u_codec.regs[1], 32'h0);
    wst(1, 1'b0);
    repeat (2) @(u_codec.nfr);
    chk("wr", u_codec.regs[1], 32'h1234);
  endtask
  task t_read;
    apb(1'b1, `ACLH_A_CMD, 32'h0082_0000);
    wst(2, 1'b1);
    apb(1'b0, `ACLH_A_RESP, 32'h0);
    chk("resp", rd, 32'h8002_1234);
    apb(1'b0, `ACLH_A_RESP, 32'h0);
    chk("clr", {31'h0, rd[31]}, 32'h0);
    apb(1'b1, `ACLH_A_CMD, 32'h0003_0000);
    apb(1'b0, `ACLH_A_STAT, 32'h0);
    chk("odd", {30'h0, rd[6], rd[1]}, 32'h2);
  endtask
  task t_pcm;
    // Start just after a frame load so all three samples share one frame
    @(u_codec.nfr);
    apb(1'b1, `ACLH_A_PCM_L, 32'habcd0);
    apb(1'b1, `ACLH_A_PCM_R, 32'h12340);
    apb(1'b1, `ACLH_A_MDM_TX, 32'h55aa0);
    wait (u_codec.got[199:180] === 20'habcd0);
    chk("tags", u_codec.got[255:243], 32'h1380);
    chk("right", u_codec.got[179:160], 32'h12340);
    chk("modem", u_codec.got[159:140], 32'h55aa0);
  endtask
  task t_mono;
    apb(1'b1, `ACLH_A_CTRL, 32'h3);
    apb(1'b1, `ACLH_A_PCM_L, 32'h24680);
    wait (u_codec.got[199:180] === 20'h24680);
    chk("mono", u_codec.got[179:160], 32'h24680);
    chk("mtag", u_codec.got[255:243], 32'h1300);
  endtask
  task t_rec;
    logic [19:0] ex [4];
    ex = '{20'hab5c0, 20'h6f3c4, 20'h9e1b0, 20'h35d28};
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, `ACLH_A_REC_L + 8'(4 * i), 32'h0);
      chk("rec", rd, {12'h800, ex[i]});
    end
    apb(1'b0, `ACLH_A_STAT, 32'h0);
    chk("rtag", {20'h0, rd[27:16]}, 32'h3c0);
  endtask
  // Hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 95000) begin
      num_errors++;
      report_and_stop;
    end
  end
  // Main sequence
  initial begin
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    t_regs;
    t_link;
    t_read;
    t_pcm;
    t_mono;
    t_rec;
    report_and_stop;
  end
endmodule
`default_nettype wire
